// ---- rtl/sap_pkg.sv ----
// package for the serial audio port: map, fields, reset values, types
package sap_pkg;
  // register byte offsets
  localparam logic [7:0] SAP_CTRL_OFS = 8'h00;
  localparam logic [7:0] SAP_STAT_OFS = 8'h04;
  localparam logic [7:0] SAP_L1_OFS = 8'h08;
  localparam logic [7:0] SAP_OUTL_OFS = 8'h18;
  localparam logic [7:0] SAP_OUTR_OFS = 8'h1C;
  // control field positions
  localparam int SAP_IN_FMT_POS = 0;
  localparam int SAP_IN_LEN_POS = 2;
  localparam int SAP_OUT_FMT_POS = 4;
  localparam int SAP_OUT_LEN_POS = 6;
  localparam int SAP_MDIV_POS = 8;
  localparam int SAP_FIFTH_POS = 10;
  localparam int SAP_OUT_EN_POS = 11;
  localparam int SAP_RATE_POS = 12;
  localparam int SAP_BDIV_POS = 16;
  localparam int SAP_BDIV_W = 8;
  // frame geometry
  localparam int SAP_SLOT_BITS = 32;
  localparam int SAP_FRAME_BITS = 64;
  localparam int SAP_CH_IN = 5;
  // reset values: i2s 24-bit in and out, divide-by-1
  localparam logic [31:0] SAP_CTRL_RST = 32'h0001_0888;
  localparam logic [1:0] SAP_RESP_OK = 2'b00;
  localparam logic [1:0] SAP_RESP_ERR = 2'b10;

  typedef enum logic [1:0] {
    SAP_FMT_I2S,
    SAP_FMT_LJ,
    SAP_FMT_RJ,
    SAP_FMT_BAD
  } sap_fmt_t;

  typedef enum logic [1:0] {
    SAP_LEN_16,
    SAP_LEN_20,
    SAP_LEN_24,
    SAP_LEN_BAD
  } sap_len_t;

  typedef struct packed {
    logic [31:0] left;
    logic [31:0] right;
  } sap_pair_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } sap_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sap_axi_rsp_t;
endpackage

// ---- rtl/sap_port.sv ----
// serial audio port master: clock generation, five inputs, one output
`timescale 1ns/1ns
`default_nettype none
// How it works
// - i2s: frame clock low carries left, high carries right
// - every framing uses 64 bit clocks per stereo frame
// - i2s first data bit comes one bit clock after frame toggle
// - msb first; inputs sampled on bit clock rising edge
// - i2s and lj inputs drop slot bits past the word length
// - lj: frame clock high for left, msb at the toggle
// - rj 24-bit: frame high for left, msb eight bits after toggle
// - rj: lsb sits in the last bit period before frame toggle
// - rj inputs drop leading slot bits before the word
// - output only i2s, lj, rj with 16, 20 or 24 bit words
// - fifth input taken only as master, on our own clocks
// - fifth input on, output off: frame clock at internal rate
// - bit clock output always 64 times the frame clock
// - master clock out is input divided by 4, 2 or 1, default 1
// - master clock ratios 64 to 768 fs accepted
// - after reset inputs are i2s with 24-bit words
module sap_port (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic MCLK_IN,
  input wire logic [4:0] SERIAL_INPUTS,
  input wire sap_pkg::sap_axi_req_t AXI_REQ,
  output sap_pkg::sap_axi_rsp_t AXI_RSP,
  output logic FRAME_CLOCK_OUTPUT,
  output logic BIT_CLOCK_OUTPUT,
  output logic MASTER_CLOCK_OUTPUT,
  output logic SERIAL_DATA_OUTPUT
);
  import sap_pkg::*;

  // synchronisers for pins
  logic [4:0] sdi_s1_q, sdi_s2_q;
  logic mck_s1_q, mck_s2_q, mck_s3_q;
  always_ff @(posedge CLK) begin
    sdi_s1_q <= SERIAL_INPUTS;
    sdi_s2_q <= sdi_s1_q;
    mck_s1_q <= MCLK_IN;
    mck_s2_q <= mck_s1_q;
    mck_s3_q <= mck_s2_q;
  end

  logic [31:0] ctrl_q;
  sap_fmt_t in_fmt, out_fmt;
  sap_len_t in_len, out_len;
  logic [1:0] mdiv;
  logic fifth_on, out_on, cfg_ok;
  logic [SAP_BDIV_W-1:0] bdiv;
  always_comb begin
    in_fmt = sap_fmt_t'(ctrl_q[SAP_IN_FMT_POS +: 2]);
    in_len = sap_len_t'(ctrl_q[SAP_IN_LEN_POS +: 2]);
    out_fmt = sap_fmt_t'(ctrl_q[SAP_OUT_FMT_POS +: 2]);
    out_len = sap_len_t'(ctrl_q[SAP_OUT_LEN_POS +: 2]);
    mdiv = ctrl_q[SAP_MDIV_POS +: 2];
    fifth_on = ctrl_q[SAP_FIFTH_POS];
    out_on = ctrl_q[SAP_OUT_EN_POS] & ~fifth_on;
    // fifth input and output share the pins, so the rate follows it
    bdiv = fifth_on ? {4'h0, ctrl_q[SAP_RATE_POS +: 4]} :
      ctrl_q[SAP_BDIV_POS +: SAP_BDIV_W];
    // mixing i2s with lj/rj flagged; output held silent then
    cfg_ok = ((in_fmt == SAP_FMT_I2S) == (out_fmt == SAP_FMT_I2S)) &&
      out_fmt != SAP_FMT_BAD && out_len != SAP_LEN_BAD;
  end

  // master clock out, divided from the synchronised input edges
  // divide-by-1 passes the synchronised pin; edges jitter by a clock
  logic [1:0] mcnt_q;
  logic mck_rise;
  assign mck_rise = mck_s2_q & ~mck_s3_q;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mcnt_q <= '0;
      MASTER_CLOCK_OUTPUT <= 1'b0;
    end else begin
      case (mdiv)
        2'd1: if (mck_rise) MASTER_CLOCK_OUTPUT <= ~MASTER_CLOCK_OUTPUT;
        2'd2: if (mck_rise) begin
          mcnt_q <= mcnt_q + 2'd1;
          if (mcnt_q[0]) MASTER_CLOCK_OUTPUT <= ~MASTER_CLOCK_OUTPUT;
        end
        default: MASTER_CLOCK_OUTPUT <= mck_s2_q;
      endcase
    end
  end

  // bit clock: half period bdiv+1 cycles; frame = 64 bit clocks
  logic [SAP_BDIV_W-1:0] hcnt_q;
  logic [5:0] bpos_q;
  logic tick_fall, tick_rise, half_done;
  // bdiv may shrink under a running count, so compare, never match
  assign half_done = hcnt_q >= bdiv;
  assign tick_fall = half_done && BIT_CLOCK_OUTPUT;
  assign tick_rise = half_done && !BIT_CLOCK_OUTPUT;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      hcnt_q <= '0;
      BIT_CLOCK_OUTPUT <= 1'b0;
      bpos_q <= '0;
    end else if (half_done) begin
      hcnt_q <= '0;
      BIT_CLOCK_OUTPUT <= ~BIT_CLOCK_OUTPUT;
      if (BIT_CLOCK_OUTPUT) bpos_q <= bpos_q + 6'd1;
    end else begin
      hcnt_q <= hcnt_q + 1'b1;
    end
  end

  // frame clock changes on the falling bit clock edge at slot start
  // a polarity change mid-run stretches one slot; set format from reset
  logic [4:0] slot_idx;
  logic right_half;
  assign slot_idx = bpos_q[4:0];
  assign right_half = bpos_q[5];
  always_ff @(posedge CLK) begin
    if (SRST) begin
      FRAME_CLOCK_OUTPUT <= 1'b0;
    end else if (tick_fall && bpos_q == 6'd63) begin
      FRAME_CLOCK_OUTPUT <= (out_fmt == SAP_FMT_I2S) ? 1'b0 : 1'b1;
    end else if (tick_fall && bpos_q == 6'd31) begin
      FRAME_CLOCK_OUTPUT <= (out_fmt == SAP_FMT_I2S) ? 1'b1 : 1'b0;
    end
  end

  function automatic logic [4:0] word_bits(input sap_len_t l);
    case (l)
      SAP_LEN_16: word_bits = 5'd16;
      SAP_LEN_20: word_bits = 5'd20;
      default: word_bits = 5'd24;
    endcase
  endfunction

  // slot position of the msb, and whether slot bit is inside the word
  function automatic logic [4:0] msb_pos(input sap_fmt_t f, input sap_len_t l);
    case (f)
      SAP_FMT_I2S: msb_pos = 5'd1;
      SAP_FMT_LJ: msb_pos = 5'd0;
      default: msb_pos = 5'(SAP_SLOT_BITS) - word_bits(l);
    endcase
  endfunction

  // receive: sample on rising bit clock; slot bits outside the word skip
  // inputs arrive two clocks late; half period must cover that and skew
  logic [4:0] in_first, in_w;
  logic in_take;
  always_comb begin
    in_first = msb_pos(in_fmt, in_len);
    in_w = word_bits(in_len);
    in_take = (slot_idx >= in_first) &&
      ({1'b0, slot_idx} < 6'(in_first) + 6'(in_w));
  end

  sap_pair_t rx_sh_q [SAP_CH_IN];
  sap_pair_t rx_hold_q [SAP_CH_IN];
  genvar ch;
  generate
    for (ch = 0; ch < SAP_CH_IN; ch++) begin : g_rx
      // fifth lane only as master on our clocks; always master here
      logic lane_on;
      assign lane_on = (ch != SAP_CH_IN - 1) || fifth_on;
      always_ff @(posedge CLK) begin
        if (SRST) begin
          rx_sh_q[ch] <= '0;
          rx_hold_q[ch] <= '0;
        end else begin
          if (tick_rise && in_take && lane_on) begin
            // left fills the first half; frame polarity follows format
            if (right_half)
              rx_sh_q[ch].right <= {rx_sh_q[ch].right[30:0], sdi_s2_q[ch]};
            else
              rx_sh_q[ch].left <= {rx_sh_q[ch].left[30:0], sdi_s2_q[ch]};
          end
          // words move to the hold at frame end, msb aligned
          if (tick_fall && bpos_q == 6'd63) begin
            rx_hold_q[ch].left <= rx_sh_q[ch].left << (6'd32 - 6'(in_w));
            rx_hold_q[ch].right <= rx_sh_q[ch].right << (6'd32 - 6'(in_w));
          end
        end
      end
    end
  endgenerate

  // transmit: msb-aligned words, changed on the falling bit clock edge
  sap_pair_t tx_q;
  logic [4:0] out_first, out_w, rel, nxt_slot;
  logic [5:0] nxt_pos;
  logic out_in_word, nxt_right, tx_live;
  logic [31:0] tx_word;
  always_comb begin
    out_first = msb_pos(out_fmt, out_len);
    out_w = word_bits(out_len);
    // the bit launched now belongs to the position that starts now
    nxt_pos = bpos_q + 6'd1;
    nxt_slot = nxt_pos[4:0];
    nxt_right = nxt_pos[5];
    rel = nxt_slot - out_first;
    out_in_word = (nxt_slot >= out_first) &&
      ({1'b0, nxt_slot} < 6'(out_first) + 6'(out_w));
    tx_live = out_on && cfg_ok && out_in_word;
    tx_word = nxt_right ? tx_q.right : tx_q.left;
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      SERIAL_DATA_OUTPUT <= 1'b0;
    end else if (tick_fall) begin
      // lj msb leaves with the frame edge, i2s msb one bit later
      if (tx_live)
        SERIAL_DATA_OUTPUT <= tx_word[5'd31 - rel];
      else
        SERIAL_DATA_OUTPUT <= 1'b0;
    end
  end

  // axi4-lite slave: write and read each take one cycle; read answers next, write a cycle later
  // one write and one read in flight; a second waits for the answer
  logic aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_ok, rd_ok;
  assign wr_ok = aw_got_q && w_got_q && !AXI_RSP.bvalid;
  assign rd_ok = AXI_REQ.arvalid && AXI_RSP.arready;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      ctrl_q <= SAP_CTRL_RST;
      tx_q <= '0;
      AXI_RSP <= '0;
    end else begin
      AXI_RSP.awready <= !aw_got_q && !AXI_RSP.awready && AXI_REQ.awvalid;
      AXI_RSP.wready <= !w_got_q && !AXI_RSP.wready && AXI_REQ.wvalid;
      if (AXI_RSP.awready && AXI_REQ.awvalid) begin
        aw_got_q <= 1'b1;
        awaddr_q <= AXI_REQ.awaddr;
      end
      if (AXI_RSP.wready && AXI_REQ.wvalid) begin
        w_got_q <= 1'b1;
        wdata_q <= AXI_REQ.wdata;
        wstrb_q <= AXI_REQ.wstrb;
      end
      if (wr_ok) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        AXI_RSP.bvalid <= 1'b1;
        AXI_RSP.bresp <= SAP_RESP_OK;
        for (int b = 0; b < 4; b++) begin
          if (wstrb_q[b]) begin
            case (awaddr_q)
              SAP_CTRL_OFS: ctrl_q[8*b +: 8] <= wdata_q[8*b +: 8];
              SAP_OUTL_OFS: tx_q.left[8*b +: 8] <= wdata_q[8*b +: 8];
              SAP_OUTR_OFS: tx_q.right[8*b +: 8] <= wdata_q[8*b +: 8];
              default: ;
            endcase
          end
        end
        if (awaddr_q != SAP_CTRL_OFS && awaddr_q != SAP_OUTL_OFS &&
            awaddr_q != SAP_OUTR_OFS)
          AXI_RSP.bresp <= SAP_RESP_ERR;
      end else if (AXI_REQ.bready && AXI_RSP.bvalid) begin
        AXI_RSP.bvalid <= 1'b0;
      end
      AXI_RSP.arready <= !AXI_RSP.rvalid && !AXI_RSP.arready &&
        AXI_REQ.arvalid;
      if (rd_ok) begin
        AXI_RSP.rvalid <= 1'b1;
        AXI_RSP.rresp <= SAP_RESP_OK;
        AXI_RSP.rdata <= '0;
        if (AXI_REQ.araddr == SAP_CTRL_OFS)
          AXI_RSP.rdata <= ctrl_q;
        else if (AXI_REQ.araddr == SAP_STAT_OFS)
          AXI_RSP.rdata <= {23'h00_0000, cfg_ok, FRAME_CLOCK_OUTPUT, bpos_q,
            1'b0};
        else if (AXI_REQ.araddr == SAP_OUTL_OFS)
          AXI_RSP.rdata <= tx_q.left;
        else if (AXI_REQ.araddr == SAP_OUTR_OFS)
          AXI_RSP.rdata <= tx_q.right;
        else if (AXI_REQ.araddr >= SAP_L1_OFS &&
                 AXI_REQ.araddr < SAP_L1_OFS + 8'h10 &&
                 AXI_REQ.araddr[1:0] == 2'b00)
          AXI_RSP.rdata <= AXI_REQ.araddr[2] ?
            rx_hold_q[AXI_REQ.araddr[4:3] - 2'd1].right :
            rx_hold_q[AXI_REQ.araddr[4:3] - 2'd1].left;
        else
          AXI_RSP.rresp <= SAP_RESP_ERR;
      end else if (AXI_REQ.rready && AXI_RSP.rvalid) begin
        AXI_RSP.rvalid <= 1'b0;
      end
    end
  end
endmodule // sap_port
`default_nettype wire

// ---- tb/sap_port_monitor.sv ----
// checker for the serial audio port clock and data outputs
`timescale 1ns/1ns
`default_nettype none
module sap_port_mon (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic FRAME_CLOCK_OUTPUT,
  input wire logic BIT_CLOCK_OUTPUT,
  input wire logic SERIAL_DATA_OUTPUT
);
  wire logic fc = FRAME_CLOCK_OUTPUT;
  wire logic bc = BIT_CLOCK_OUTPUT;
  wire logic sd = SERIAL_DATA_OUTPUT;
  logic [6:0] slot_q;
  logic [6:0] frm_q;
  logic [1:0] seen_q;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SRST);
  sequence s_bit_fall;
    $fell(bc);
  endsequence
  // counts are partial until two frame edges have passed
  always_ff @(posedge CLK) begin
    if (SRST) begin
      slot_q <= 7'h00;
      frm_q <= 7'h00;
      seen_q <= 2'h0;
    end else begin
      if ($changed(fc)) begin
        slot_q <= 7'h00;
        if (seen_q != 2'h3) seen_q <= seen_q + 2'h1;
      end else if ($rose(bc)) slot_q <= slot_q + 7'h01;
      if ($rose(fc)) frm_q <= 7'h00;
      else if ($rose(bc)) frm_q <= frm_q + 7'h01;
    end
  end
  a_slot_bits: assert property (
    $changed(fc) && seen_q != 2'h0 |-> slot_q == 7'h20)
    else $error("bit count per slot wrong");
  a_frame_bits: assert property (
    $rose(fc) && seen_q == 2'h3 |-> frm_q == 7'h40)
    else $error("bit count per frame wrong");
  a_data_fall: assert property ($changed(sd) |-> s_bit_fall)
    else $error("data moved off bit clock fall");
  a_frame_fall: assert property ($changed(fc) |-> s_bit_fall)
    else $error("frame moved off bit clock fall");
  a_frame_holds: assert property (
    $changed(fc) |=> $stable(fc) [*8])
    else $error("frame clock glitch");
  a_bit_runs: assert property (
    $changed(bc) |-> ##[1:600] $changed(bc))
    else $error("bit clock stalled");
  a_reset_quiet: assert property (
    $fell(SRST) |-> !fc && !bc && !sd)
    else $error("outputs not idle after reset");
  a_clock_start: assert property (
    $fell(SRST) |-> ##[1:1000] $changed(bc))
    else $error("bit clock never started");
endmodule // sap_port_mon
bind sap_port sap_port_mon i_sap_port_mon (.CLK(CLK), .SRST(SRST),
  .FRAME_CLOCK_OUTPUT(FRAME_CLOCK_OUTPUT),
  .BIT_CLOCK_OUTPUT(BIT_CLOCK_OUTPUT),
  .SERIAL_DATA_OUTPUT(SERIAL_DATA_OUTPUT));
`default_nettype wire

// ---- tb/sap_src.sv ----
// source model: serial words timed from the port's own clocks
`timescale 1ns/1ns
`default_nettype none
module sap_src (
  input wire logic clk,
  input wire logic fc,
  input wire logic bc,
  input wire logic [1:0] fmt,
  input wire logic [4:0] len,
  input wire logic [31:0] lw,
  input wire logic [31:0] rw,
  output logic [4:0] sdi,
  output logic [5:0] pos
);
  logic b_q = 1'b0;
  logic f_q = 1'b0;
  logic [5:0] p_q = 6'h00;
  logic [31:0] w;
  int k;
  assign pos = p_q;
  // launch on bit clock fall so data is steady at the rise
  always_ff @(posedge clk) begin
    b_q <= bc;
    if (b_q && !bc) begin
      f_q <= fc;
      p_q <= (fc != f_q) ? 6'h00 : p_q + 6'h01;
    end
  end
  always_comb begin
    w = (fmt == 2'h0) ^ fc ? lw : rw;
    k = int'(p_q) - ((fmt == 2'h0) ? 1 : 0);
    if (fmt == 2'h2) k = int'(p_q) + int'(len) - 32;
    // outside the word the line toggles, so masking is exercised
    sdi = {5{p_q[0]}};
    if (k >= 0 && k < int'(len)) sdi = {5{w[int'(len) - 1 - k]}};
  end
endmodule // sap_src
`default_nettype wire

// ---- tb/tb_sap_port.sv ----
// self-checking bench for the serial audio port
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) chk(n, 32'(e), 32'(s))
module tb_sap_port;
  import sap_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic mclk_in = 1'b0;
  sap_axi_req_t req = '0;
  sap_axi_rsp_t rsp;
  logic fco, bco, mco, sdo, bq;
  logic [4:0] sdi;
  logic [5:0] pos;
  logic [1:0] fmt = 2'h0;
  logic [1:0] rr;
  logic [4:0] len = 5'h18;
  logic [31:0] lw = 32'h00ab_cdef;
  logic [31:0] rw = 32'h0012_3456;
  logic [31:0] rdat;
  int num_errors = 0;
  int check_count = 0;
  int cnt;
  int hits;
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    forever #80 mclk_in = ~mclk_in;
  end
  sap_port i_sap_port (.CLK(clk), .SRST(srst), .MCLK_IN(mclk_in),
    .SERIAL_INPUTS(sdi), .AXI_REQ(req), .AXI_RSP(rsp),
    .FRAME_CLOCK_OUTPUT(fco), .BIT_CLOCK_OUTPUT(bco),
    .MASTER_CLOCK_OUTPUT(mco), .SERIAL_DATA_OUTPUT(sdo));
  sap_src i_sap_src (.clk(clk), .fc(fco), .bc(bco), .fmt(fmt), .len(len),
    .lw(lw), .rw(rw), .sdi(sdi), .pos(pos));
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic tmo(int n);
    if (n >= 200) begin
      num_errors++;
      $display("BAD bus_wait exp answer got none");
      close_out();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    int n = 0;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid && n < 200);
    req.bready <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(logic [7:0] a);
    int n = 0;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid && n < 200);
    rdat = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
    tmo(n);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd(SAP_CTRL_OFS);
    `CHK("in_fmt", SAP_FMT_I2S, rdat[1:0]);
    `CHK("in_len", SAP_LEN_24, rdat[3:2]);
    `CHK("mclk_div", 2'h0, rdat[9:8]);
    rd(8'h40);
    `CHK("unmapped", SAP_RESP_ERR, rr);
    $display("test defaults done");
    // both sides stay on one side of the i2s split
    for (int f = 0; f < 3; f++) begin
      for (int l = 0; l < 3; l += 2) begin
        // frame polarity flips only out of reset, before the first edge
        if (f == 1 && l == 0) begin
          srst <= 1'b1;
          repeat (4) @(posedge clk);
          srst <= 1'b0;
        end
        fmt <= f[1:0];
        len <= (l == 0) ? 5'h10 : 5'h18;
        // half period of 5 clocks covers the input synchronisers
        wr(SAP_CTRL_OFS, {16'h0004, 8'h08, 2'h2,
          (f == 0) ? 2'h0 : 2'h1, l[1:0], f[1:0]});
        repeat (1400) @(posedge clk);
        rd(SAP_L1_OFS);
        `CHK("left", lw << (32 - len), rdat);
        rd(SAP_L1_OFS + 8'h04);
        `CHK("right", rw << (32 - len), rdat);
      end
    end
    $display("test input framing done");
    for (int d = 0; d < 3; d++) begin
      wr(SAP_CTRL_OFS, {16'h0001, 6'h02, d[1:0], 8'h55});
      repeat (32) @(posedge clk);
      cnt = 0;
      bq = mco;
      repeat (640) begin
        @(posedge clk);
        if (mco && !bq) cnt++;
        bq = mco;
      end
      `CHK("mclk_out", 1'b1, (cnt - (80 >> d)) inside {[-1:1]});
    end
    $display("test master clock done");
    fmt <= 2'h1;
    len <= 5'h18;
    wr(SAP_CTRL_OFS, {16'h0001, 8'h08, 8'h19});
    wr(SAP_OUTL_OFS, 32'hffff_ffff);
    wr(SAP_OUTR_OFS, 32'hffff_ffff);
    repeat (600) @(posedge clk);
    bq = 1'b1;
    repeat (260) begin
      @(posedge clk);
      if (bco && !bq) `CHK("sdo", pos < 6'h10, sdo);
      bq = bco;
    end
    $display("test output padding done");
    rd(SAP_STAT_OFS);
    `CHK("cfg_legal", 1'b1, rdat[8]);
    // fifth input on: output off, bit clock from the rate field
    wr(SAP_CTRL_OFS, {16'h0001, 8'h2c, 8'h19});
    repeat (64) @(posedge clk);
    cnt = 0;
    hits = 0;
    bq = bco;
    repeat (600) begin
      @(posedge clk);
      if (bco && !bq) cnt++;
      if (sdo) hits++;
      bq = bco;
    end
    `CHK("rate_bits", 1'b1, (cnt - 100) inside {[-1:1]});
    `CHK("out_off", 0, hits);
    wr(SAP_CTRL_OFS, {16'h0001, 8'h08, 8'h18});
    rd(SAP_STAT_OFS);
    `CHK("cfg_mixed", 1'b0, rdat[8]);
    $display("test fifth input and status done");
    close_out();
  end
endmodule // tb_sap_port
`default_nettype wire
